/* sfs_sram_port.v */
// synchronous flow-through burst sram port: controls, burst counter, data pins
//
// Contract
// - The device is selected only when select a is low, select b high and select c low.
// - The output enable is active low and lets the data pins drive only while internal logic allows.
// - Data and parity pins float during write data, on the first clock after deselect, and while deselected.
// - A high clock qualifier masks clock edges and holds the access state; sleep sequencing, pin synchronisers and drive enables still update.
// - Raising the clock qualifier never deselects and keeps the current result on the pins.
// - A high sleep request puts the device into sleep with memory contents kept.
// - Data lines acting as inputs are captured into a data register on the rising edge.
// - A read drives, flow-through, the word addressed at the edge that started it.
// - Parity lines behave like data lines and are written only with their own byte lane.
// - A low burst-order strap selects linear bursts, high or floating selects interleaved.
// - With all selects active and load low, a high write strobe starts a read and a low one a write.
// - Write data and parity are latched at the qualified edge after the address edge, per lane.
// - Advance high steps the two-bit burst counter, ignores selects and strobe, keeps the op type.
// - Sleep takes two cycles to enter or leave and the controller deselects before asking.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_regs.vh"

module sfs_sram_port #(
  parameter ADDR_W = `SFS_ADDR_W,
  parameter DATA_W = `SFS_DATA_W,
  parameter LANES = `SFS_LANES
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // synchronous controls
  input wire [ADDR_W-1:0] addr,
  input wire advance_or_load,
  input wire write_strobe_n,
  input wire [LANES-1:0] byte_write_select_n,
  input wire chip_select_a_n,
  input wire chip_select_b,
  input wire chip_select_c_n,
  input wire clock_qualifier_n,
  // asynchronous controls and strap
  input wire output_enable_n,
  input wire sleep_request,
  input wire burst_order_strap,
  // data lines
  input wire [DATA_W-1:0] data_in,
  output reg [DATA_W-1:0] data_out,
  output reg data_oe,
  // parity lines
  input wire [LANES-1:0] parity_in,
  output reg [LANES-1:0] parity_out,
  output reg parity_oe,
  // status
  output reg sleep_active
);

  localparam LANE_W = `SFS_LANE_W;
  localparam BYTE_W = `SFS_BYTE_W;
  localparam BW = `SFS_BURST_W;
  localparam SW = `SFS_SLEEP_CNT_W;
  localparam [1:0] ST_AWAKE = `SFS_ST_AWAKE;
  localparam [1:0] ST_ENTER = `SFS_ST_ENTER;
  localparam [1:0] ST_ASLEEP = `SFS_ST_ASLEEP;
  localparam [1:0] ST_LEAVE = `SFS_ST_LEAVE;

  // three-flop synchronisers for the pins that are not on this clock
  reg [2:0] oe_sync;
  reg [2:0] sleep_sync;
  reg [2:0] strap_sync;
  reg oe_n_level;
  reg sleep_level;
  reg strap_level;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_sync <= {3{`SFS_OE_N_RESET}};
      sleep_sync <= {3{`SFS_SLEEP_RESET}};
      strap_sync <= {3{`SFS_STRAP_RESET}};
      oe_n_level <= `SFS_OE_N_RESET;
      sleep_level <= `SFS_SLEEP_RESET;
      strap_level <= `SFS_STRAP_RESET;
    end else begin
      oe_sync <= {oe_sync[1:0], output_enable_n};
      sleep_sync <= {sleep_sync[1:0], sleep_request};
      strap_sync <= {strap_sync[1:0], burst_order_strap};
      if (oe_sync[1] == oe_sync[2]) begin
        oe_n_level <= oe_sync[2];
      end
      if (sleep_sync[1] == sleep_sync[2]) begin
        sleep_level <= sleep_sync[2];
      end
      if (strap_sync[1] == strap_sync[2]) begin
        strap_level <= strap_sync[2];
      end
    end
  end

  // access state
  reg op_active;
  reg op_write;
  reg [ADDR_W-1:0] base_addr;
  reg [BW-1:0] burst_cnt;
  reg wr_pending;
  reg [ADDR_W-1:0] wr_addr_q;
  reg [LANES-1:0] wr_lane_q;
  reg read_beat;
  reg emerge;
  reg [LANES*LANE_W-1:0] data_reg;
  reg [1:0] sleep_state;
  reg [SW-1:0] sleep_cnt;

  reg next_active;
  reg next_write;
  reg [ADDR_W-1:0] next_base;
  reg [BW-1:0] next_cnt;
  reg next_wr_pending;
  reg [ADDR_W-1:0] next_wr_addr;
  reg [LANES-1:0] next_wr_lane;
  reg next_read_beat;
  reg next_emerge;
  reg [1:0] next_sleep_state;
  reg [SW-1:0] next_sleep_cnt;
  reg access;
  reg [ADDR_W-1:0] acc_addr;
  reg [BW-1:0] beat_low;

  wire qualified = !clock_qualifier_n;
  wire selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire awake = (sleep_state == ST_AWAKE);
  wire wr_commit = qualified && wr_pending;
  wire [LANES*LANE_W-1:0] pin_word;
  wire [LANES*LANE_W-1:0] mem_word;
  wire [LANES*LANE_W-1:0] read_word;

  // burst beat address from the start bits and the beat count
  always @* begin
    beat_low = `SFS_BURST_ZERO;
    if (strap_level) begin
      beat_low = base_addr[BW-1:0] ^ (burst_cnt + `SFS_BURST_STEP);
    end else begin
      beat_low = base_addr[BW-1:0] + (burst_cnt + `SFS_BURST_STEP);
    end
  end

  // next access state
  always @* begin
    next_active = op_active;
    next_write = op_write;
    next_base = base_addr;
    next_cnt = burst_cnt;
    next_wr_pending = wr_pending;
    next_wr_addr = wr_addr_q;
    next_wr_lane = wr_lane_q;
    next_read_beat = read_beat;
    next_emerge = emerge;
    access = 1'b0;
    acc_addr = base_addr;
    if (!awake) begin
      // pending work is dropped on the way into sleep
      next_active = 1'b0;
      next_wr_pending = 1'b0;
      next_read_beat = 1'b0;
      next_emerge = 1'b0;
    end else if (qualified) begin
      next_wr_pending = 1'b0;
      if (!advance_or_load) begin
        if (selected) begin
          access = 1'b1;
          acc_addr = addr;
          next_active = 1'b1;
          next_write = !write_strobe_n;
          next_base = addr;
          next_cnt = `SFS_BURST_ZERO;
          next_emerge = !op_active;
        end else begin
          next_active = 1'b0;
          next_emerge = 1'b0;
        end
      end else if (op_active) begin
        // selects and strobe ignored
        access = 1'b1;
        acc_addr = {base_addr[ADDR_W-1:BW], beat_low};
        next_cnt = burst_cnt + `SFS_BURST_STEP;
        next_emerge = 1'b0;
      end
      next_read_beat = access && !next_write;
      if (access && next_write) begin
        next_wr_pending = 1'b1;
        next_wr_addr = acc_addr;
        next_wr_lane = byte_write_select_n;
      end
    end
  end

  // sleep entry and exit sequencing
  always @* begin
    next_sleep_state = sleep_state;
    next_sleep_cnt = sleep_cnt;
    case (sleep_state)
      ST_AWAKE: begin
        if (sleep_level) begin
          next_sleep_state = ST_ENTER;
          next_sleep_cnt = `SFS_SLEEP_CYCLES - 2'h1;
        end
      end
      ST_ENTER: begin
        if (sleep_cnt == 2'h1) begin
          next_sleep_state = ST_ASLEEP;
        end
        next_sleep_cnt = sleep_cnt - 2'h1;
      end
      ST_ASLEEP: begin
        if (!sleep_level) begin
          next_sleep_state = ST_LEAVE;
          next_sleep_cnt = `SFS_SLEEP_CYCLES - 2'h1;
        end
      end
      ST_LEAVE: begin
        if (sleep_cnt == 2'h1) begin
          next_sleep_state = ST_AWAKE;
        end
        next_sleep_cnt = sleep_cnt - 2'h1;
      end
      default: begin
        next_sleep_state = ST_AWAKE;
        next_sleep_cnt = 2'h0;
      end
    endcase
  end

  // pin lanes packed as parity over data, with write-to-read bypass
  genvar k;
  generate
    for (k = 0; k < LANES; k = k + 1) begin : g_lane
      assign pin_word[k*LANE_W +: LANE_W] = {parity_in[k], data_in[k*BYTE_W +: BYTE_W]};
      assign read_word[k*LANE_W +: LANE_W] =
        (wr_commit && !wr_lane_q[k] && (wr_addr_q == acc_addr)) ?
        pin_word[k*LANE_W +: LANE_W] : mem_word[k*LANE_W +: LANE_W];
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          data_out[k*BYTE_W +: BYTE_W] <= {BYTE_W{1'b0}};
          parity_out[k] <= 1'b0;
        end else if (awake && qualified && access && !next_write) begin
          // held while the qualifier is high
          data_out[k*BYTE_W +: BYTE_W] <= read_word[k*LANE_W +: BYTE_W];
          parity_out[k] <= read_word[k*LANE_W + BYTE_W];
        end
      end
    end
  endgenerate

  sfs_mem_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .core_clk(core_clk),
    .wr_en(wr_commit && awake),
    .wr_addr(wr_addr_q),
    .wr_lane_n(wr_lane_q),
    .wr_data(pin_word),
    .rd_addr(acc_addr),
    .rd_data(mem_word)
  );

  // state registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_active <= 1'b0;
      op_write <= 1'b0;
      base_addr <= {ADDR_W{1'b0}};
      burst_cnt <= `SFS_BURST_ZERO;
      wr_pending <= 1'b0;
      wr_addr_q <= {ADDR_W{1'b0}};
      wr_lane_q <= {LANES{1'b1}};
      read_beat <= 1'b0;
      emerge <= 1'b0;
      data_reg <= {(LANES*LANE_W){1'b0}};
      sleep_state <= ST_AWAKE;
      sleep_cnt <= 2'h0;
      sleep_active <= 1'b0;
      data_oe <= 1'b0;
      parity_oe <= 1'b0;
    end else begin
      op_active <= next_active;
      op_write <= next_write;
      base_addr <= next_base;
      burst_cnt <= next_cnt;
      wr_pending <= next_wr_pending;
      wr_addr_q <= next_wr_addr;
      wr_lane_q <= next_wr_lane;
      read_beat <= next_read_beat;
      emerge <= next_emerge;
      if (qualified && !data_oe) begin
        data_reg <= pin_word;
      end
      sleep_state <= next_sleep_state;
      sleep_cnt <= next_sleep_cnt;
      sleep_active <= (next_sleep_state != ST_AWAKE);
      // drive only on a read beat that follows a selected cycle
      data_oe <= next_read_beat && !next_emerge && !oe_n_level &&
        (next_sleep_state == ST_AWAKE);
      parity_oe <= next_read_beat && !next_emerge && !oe_n_level &&
        (next_sleep_state == ST_AWAKE);
    end
  end

endmodule
`default_nettype wire

/* sfs_regs.vh */
// shared widths, encodings and timing counts for the flow-through sram port
`ifndef SFS_REGS_VH
`define SFS_REGS_VH

// array shape: 256k words, two byte lanes of eight data bits and one parity bit
`define SFS_ADDR_W 18
`define SFS_DATA_W 16
`define SFS_LANES 2
`define SFS_BYTE_W 8
`define SFS_LANE_W 9

// burst counter on the low address bits
`define SFS_BURST_W 2
`define SFS_BURST_ZERO 2'h0
`define SFS_BURST_STEP 2'h1

// sleep entry and exit, in clock cycles
`define SFS_SLEEP_CYCLES 2'h2
`define SFS_SLEEP_CNT_W 2

// sleep state encodings
`define SFS_ST_AWAKE 2'h0
`define SFS_ST_ENTER 2'h1
`define SFS_ST_ASLEEP 2'h2
`define SFS_ST_LEAVE 2'h3

// reset levels of the pin synchronisers
`define SFS_OE_N_RESET 1'h1
`define SFS_SLEEP_RESET 1'h0
`define SFS_STRAP_RESET 1'h1

`endif

/* sfs_mem_array.v */
// storage array with per-lane write enables and a combinational read port
`timescale 1ns/100ps
`default_nettype none
`include "sfs_regs.vh"

module sfs_mem_array #(
  parameter ADDR_W = `SFS_ADDR_W,
  parameter LANES = `SFS_LANES,
  parameter LANE_W = `SFS_LANE_W
) (
  // clock
  input wire core_clk,
  // write port
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [LANES-1:0] wr_lane_n,
  input wire [LANES*LANE_W-1:0] wr_data,
  // read port
  input wire [ADDR_W-1:0] rd_addr,
  output wire [LANES*LANE_W-1:0] rd_data
);

  genvar k;
  generate
    for (k = 0; k < LANES; k = k + 1) begin : g_lane
      // contents survive sleep and carry no reset
      reg [LANE_W-1:0] store [0:(1<<ADDR_W)-1];
      always @(posedge core_clk) begin
        if (wr_en && !wr_lane_n[k]) begin
          store[wr_addr] <= wr_data[k*LANE_W +: LANE_W];
        end
      end
      assign rd_data[k*LANE_W +: LANE_W] = store[rd_addr];
    end
  endgenerate

endmodule
`default_nettype wire

/* sfs_sram_monitor_monitor.sv */
// pin-level assertions for the flow-through sram port
`timescale 1ns/100ps
`default_nettype none
module sfs_sram_monitor #(
  parameter DATA_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // controls
  input wire logic advance_or_load,
  input wire logic write_strobe_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic clock_qualifier_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // outputs
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic parity_oe,
  input wire logic sleep_active
);
  wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire ld = !clock_qualifier_n && !sleep_active && !advance_or_load;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  pair_oe_a: assert property (data_oe == parity_oe) else $error("oe differ");
  desel_float_a: assert property (ld && !sel |=> !data_oe)
    else $error("drive while deselected");
  write_float_a: assert property (ld && sel && !write_strobe_n |=> !data_oe)
    else $error("drive in write data");
  emerge_float_a: assert property (ld && !sel ##1 ld && sel |=> !data_oe)
    else $error("drive after deselect");
  qual_hold_a: assert property (clock_qualifier_n && !sleep_active |=> $stable(data_out))
    else $error("data moved while masked");
  oe_off_a: assert property (output_enable_n [*5] |=> !data_oe)
    else $error("drive with oe high");
  sleep_on_a: assert property (sleep_request [*8] |-> sleep_active)
    else $error("no sleep");
  sleep_off_a: assert property (!sleep_request [*8] |-> !sleep_active)
    else $error("no wake");
  sleep_min_a: assert property ($rose(sleep_active) |=> sleep_active)
    else $error("sleep too short");
endmodule
bind sfs_sram_port sfs_sram_monitor #(.DATA_W(DATA_W)) sfs_sram_monitor_inst (
  .core_clk(core_clk), .rst_n(rst_n), .advance_or_load(advance_or_load),
  .write_strobe_n(write_strobe_n), .chip_select_a_n(chip_select_a_n),
  .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
  .clock_qualifier_n(clock_qualifier_n), .output_enable_n(output_enable_n),
  .sleep_request(sleep_request), .data_out(data_out), .data_oe(data_oe),
  .parity_oe(parity_oe), .sleep_active(sleep_active));
`default_nettype wire

/* sfs_ctrl_model.sv */
// controller side of the shared data and parity pins
`timescale 1ns/100ps
`default_nettype none
module sfs_ctrl_model (
  // device pins
  input wire logic core_clk,
  input wire logic data_oe,
  input wire logic parity_oe,
  input wire logic [15:0] data_out,
  input wire logic [1:0] parity_out,
  // write data from the bench
  input wire logic drive,
  input wire logic [17:0] wdata,
  // resolved levels
  output logic [15:0] data_in,
  output logic [1:0] parity_in
);
  logic [17:0] last;
  // controller stays off while the device drives; unheld lines wander
  always @* begin
    data_in = data_oe ? data_out : (drive ? wdata[15:0] : ~last[15:0]);
    parity_in = parity_oe ? parity_out : (drive ? wdata[17:16] : ~last[17:16]);
  end
  always @(posedge core_clk) last <= {parity_in, data_in};
endmodule
`default_nettype wire

/* sfs_sram_port_bench.sv */
// self-checking bench for the flow-through sram port
`timescale 1ns/100ps
`default_nettype none
module sfs_sram_port_bench;
  logic core_clk, rst_n, advance_or_load, write_strobe_n, chip_select_a_n, chip_select_b;
  logic chip_select_c_n, clock_qualifier_n, output_enable_n, sleep_request, burst_order_strap;
  logic drive, data_oe, parity_oe, sleep_active;
  logic [17:0] addr, wdata;
  logic [1:0] byte_write_select_n, parity_in, parity_out;
  logic [15:0] data_in, data_out;
  integer failures, cmp_count, i;
  sfs_sram_port #(.ADDR_W(18), .DATA_W(16), .LANES(2)) sfs_sram_port_inst (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .advance_or_load(advance_or_load),
    .write_strobe_n(write_strobe_n), .byte_write_select_n(byte_write_select_n),
    .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
    .chip_select_c_n(chip_select_c_n), .clock_qualifier_n(clock_qualifier_n),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .burst_order_strap(burst_order_strap), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .parity_in(parity_in), .parity_out(parity_out),
    .parity_oe(parity_oe), .sleep_active(sleep_active));
  sfs_ctrl_model sfs_ctrl_model_inst (.core_clk(core_clk), .data_oe(data_oe),
    .parity_oe(parity_oe), .data_out(data_out), .parity_out(parity_out), .drive(drive),
    .wdata(wdata), .data_in(data_in), .parity_in(parity_in));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // drive one cycle at this edge; returns at the edge that takes it
  task op(input logic adv, input logic [2:0] cs, input logic wr_n, input logic [17:0] a,
      input logic [1:0] bw, input logic drv, input logic [17:0] d);
    advance_or_load <= adv;
    {chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
    write_strobe_n <= wr_n;
    addr <= a;
    byte_write_select_n <= bw;
    drive <= drv;
    wdata <= d;
    @(posedge core_clk);
  endtask
  task rd(input logic [17:0] a);
    op(0, 3'b010, 1, a, 2'b11, 0, 18'h0_0000);
  endtask
  task nop;
    op(0, 3'b000, 1, 18'h0_0000, 2'b11, 0, 18'h0_0000);
  endtask
  task chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // results are seen one op late
  task t_write_read;
    op(0, 3'b010, 0, 18'h0_0010, 2'b00, 0, 18'h0_0000);
    op(0, 3'b010, 0, 18'h0_0010, 2'b10, 1, 18'h3_1234);
    chk(data_oe, 1'b0);
    op(0, 3'b000, 1, 18'h0_0000, 2'b11, 1, 18'h0_00ab);
    rd(18'h0_0010);
    rd(18'h0_0010);
    chk({parity_out, data_out}, 18'h2_12ab);
    chk(data_oe, 1'b0);
    nop;
    chk({parity_out, data_out}, 18'h2_12ab);
    chk(data_oe, 1'b1);
    $display("test write_read done");
  endtask
  task t_select;
    // each pass: deselect by pattern i, emerging read, then a driving read
    for (i = 0; i < 8; i = i + 1) if (i != 2) begin
      op(0, i[2:0], 1, 18'h0_0010, 2'b11, 0, 18'h0_0000);
      rd(18'h0_0010);
      chk(data_oe, 1'b0);
      rd(18'h0_0010);
      chk(data_oe, 1'b0);
      rd(18'h0_0010);
      chk(data_oe, 1'b1);
    end
    $display("test select done");
  endtask
  task t_burst;
    op(0, 3'b010, 0, 18'h0_0022, 2'b00, 0, 18'h0_0000);
    for (i = 0; i < 3; i = i + 1) op(1, 3'b000, 1, 18'h0_0000, 2'b00, 1, 18'h0_00a0 + i[17:0]);
    op(0, 3'b000, 1, 18'h0_0000, 2'b11, 1, 18'h0_00a3);
    burst_order_strap <= 0;
    repeat (4) nop;
    rd(18'h0_0023);
    for (i = 1; i < 4; i = i + 1) begin
      op(1, 3'b000, 0, 18'h0_0000, 2'b11, 0, 18'h0_0000);
      chk({parity_out, data_out}, 18'h0_00a0 + i[17:0]);
    end
    clock_qualifier_n <= 1;
    repeat (3) begin
      rd(18'h0_0010);
      chk({parity_out, data_out}, 18'h0_00a0);
      chk(data_oe, 1'b1);
    end
    clock_qualifier_n <= 0;
    $display("test burst done");
  endtask
  task t_oe;
    output_enable_n <= 1;
    repeat (6) rd(18'h0_0010);
    chk(data_oe, 1'b0);
    output_enable_n <= 0;
    repeat (6) rd(18'h0_0010);
    chk(data_oe, 1'b1);
    $display("test oe done");
  endtask
  task t_sleep;
    nop;
    sleep_request <= 1;
    for (i = 0; i < 10 && sleep_active !== 1'b1; i = i + 1) nop;
    chk(sleep_active, 1'b1);
    repeat (4) nop;
    sleep_request <= 0;
    for (i = 0; i < 10 && sleep_active !== 1'b0; i = i + 1) nop;
    chk(sleep_active, 1'b0);
    repeat (2) nop;
    // a word not on the pins before sleep, so the array itself is read
    rd(18'h0_0022);
    rd(18'h0_0022);
    chk({parity_out, data_out}, 18'h0_00a0);
    $display("test sleep done");
  endtask
  initial begin
    #200000;
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    rst_n = 0;
    {advance_or_load, chip_select_a_n, chip_select_b, chip_select_c_n} = 4'h0;
    {write_strobe_n, burst_order_strap, byte_write_select_n} = 4'hf;
    {clock_qualifier_n, output_enable_n, sleep_request, drive} = 4'h0;
    addr = 18'h0_0000;
    wdata = 18'h0_0000;
    failures = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1;
    repeat (4) nop;
    t_write_read;
    t_select;
    t_burst;
    t_oe;
    t_sleep;
    end_of_test;
  end
endmodule
`default_nettype wire
